// ### rtl/exc_defs.svh
`ifndef EXC_DEFS_SVH
`define EXC_DEFS_SVH

// Register byte offsets
`define OFF_PRIO_A 8'h00
`define OFF_PRIO_B 8'h04
`define OFF_PRIO_C 8'h08
`define OFF_PRIO_D 8'h0c
`define OFF_PRIO_E 8'h10
`define OFF_STATUS 8'h14
`define OFF_FAULT 8'h18

// Reset values and NMI mask level
`define PRIO_RESET 16'h0000
`define MASK_RESET 4'hf
`define NMI_MASK 4'hf

// Vector numbers
`define VEC_POR_PC 8'h00
`define VEC_MAN_PC 8'h02
`define VEC_CPU_AE 8'h09
`define VEC_DMA_AE 8'h0a
`define VEC_NMI 8'h0b
`define VEC_UBRK 8'h0c
`define VEC_GRP_BASE 8'h40

// Fixed priority levels
`define UBRK_LEVEL 5'h0f

// Status word field
`define SR_MASK_LSB 4

// Access size codes
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/exc_pkg.sv
package exc_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'h0,
    ST_DRAIN = 4'h1,
    ST_HOLD = 4'h2,
    ST_VEC_PC = 4'h3,
    ST_VEC_SP = 4'h4,
    ST_PUSH_SR = 4'h5,
    ST_PUSH_PC = 4'h6,
    ST_VEC_FETCH = 4'h7,
    ST_LOAD = 4'h8
  } seq_state_t;
endpackage

// ### rtl/exc_seq.sv
`timescale 1ns/1ps
`include "exc_defs.svh"

// Operation
// - Reset outranks all exceptions; only power-on and manual reset kinds exist.
// - Init pin low with NMI high: power-on reset of CPU and all peripherals.
// - Init pin low with NMI low: manual reset, bus/pin/port units untouched.
// - Reset processing starts when init pin rises; NMI level picks the kind.
// - Fetch PC then SP, clear vector base, mask to 1111, load and run.
// - Manual reset uses the same fetch and initialisation steps.
// - Manual reset waits for a running bus cycle to finish.
// - Instruction fetch from odd address is an address error.
// - Instruction fetch from peripheral space is an address error.
// - Word data access at odd address by CPU or DMA errs.
// - Long-word data access not multiple of four errs.
// - Peripheral space: long-word errs only in 8-bit part.
// - Address error processing waits for bus cycle and instructions to finish.
// - Address error: push status word, push next PC, fetch vector, branch.
// - Accept NMI, user break, eight request lines and on-chip sources.
// - NMI priority 16 always accepted; user break priority 15.
// - Request lines and on-chip sources use programmable levels 0 to 15.
// - Among pending interrupts the highest priority is taken.
// - Maskable interrupt taken only if level exceeds the mask.
// - Interrupt: push status word and PC, set mask, fetch vector, branch.
// - NMI writes 15 into the mask.
// - Power-on vectors at 0 and 4; manual vectors at 8 and 0xC.
// - Vector address is base plus four times number; resets use no base.
module exc_seq #(
  parameter logic [31:0] PERIPH_MASK = 32'hffff_0000,
  parameter logic [31:0] PERIPH_BASE = 32'hffff_0000,
  parameter logic [31:0] P8_MASK = 32'hffff_ff00,
  parameter logic [31:0] P8_BASE = 32'hffff_ff00
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Device pins
  input wire logic nmi_pin,
  input wire logic chip_init_pin,
  input wire logic [7:0] external_request_lines,
  // On-chip interrupt requests
  input wire logic ubrk_req,
  input wire logic [3:0] dma_req,
  input wire logic [14:0] timer_req,
  input wire logic [7:0] serial_req,
  input wire logic wdt_req,
  input wire logic [1:0] bsc_req,
  // Bus access monitor
  input wire logic acc_valid,
  input wire logic acc_dma,
  input wire logic acc_fetch,
  input wire logic [1:0] acc_size,
  input wire logic [31:0] acc_addr,
  input wire logic bus_busy,
  // Pipeline state
  input wire logic int_window,
  input wire logic ae_window,
  input wire logic [31:0] cur_sr,
  input wire logic [31:0] cur_pc,
  input wire logic [31:0] cur_sp,
  input wire logic [31:0] vector_table_base,
  // Pipeline control
  output logic cpu_stall,
  output logic load_valid,
  output logic [31:0] load_pc,
  output logic [31:0] load_sp,
  output logic [31:0] load_sr,
  output logic vbr_clear,
  output logic addr_error,
  output logic core_rst_n,
  output logic sys_rst_n,
  // Exception memory port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NGRP = 20;

  // Register index, 7 when unmapped
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    unique case (a)
      `OFF_PRIO_A: return 3'h0;
      `OFF_PRIO_B: return 3'h1;
      `OFF_PRIO_C: return 3'h2;
      `OFF_PRIO_D: return 3'h3;
      `OFF_PRIO_E: return 3'h4;
      `OFF_STATUS: return 3'h5;
      `OFF_FAULT: return 3'h6;
      default: return 3'h7;
    endcase
  endfunction
  exc_pkg::seq_state_t state_q, state_d;
  logic init_s1_q, init_s_q, nmi_s1_q, nmi_s_q, nmi_d1_q;
  logic [7:0] ext_s1_q, ext_s_q;
  logic kind_q;
  logic nmi_pend_q, ae_cpu_q, ae_dma_q;
  logic [31:0] fault_q;
  logic [7:0] vec_q;
  logic [3:0] mask_q;
  logic rst_seq_q;
  logic [31:0] sr_q, ret_q, sp_q, pc_q, vbr_q;
  logic [15:0] prio_q [0:4];
  logic core_rst_q, sys_rst_q, ae_pulse_q;

  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_s1_q <= 1'b0;
      init_s_q <= 1'b0;
      nmi_s1_q <= 1'b1;
      nmi_s_q <= 1'b1;
      nmi_d1_q <= 1'b1;
      ext_s1_q <= 8'h00;
      ext_s_q <= 8'h00;
    end else begin
      init_s1_q <= chip_init_pin;
      init_s_q <= init_s1_q;
      nmi_s1_q <= nmi_pin;
      nmi_s_q <= nmi_s1_q;
      nmi_d1_q <= nmi_s_q;
      ext_s1_q <= external_request_lines;
      ext_s_q <= ext_s1_q;
    end
  end

  // Address error detection
  wire periph = (acc_addr & PERIPH_MASK) == PERIPH_BASE;
  wire periph8 = periph && ((acc_addr & P8_MASK) == P8_BASE);
  wire fetch_err = acc_addr[0] | periph;
  wire word_err = (acc_size == `SZ_WORD) && acc_addr[0];
  wire long_err = (acc_size == `SZ_LONG) && ((acc_addr[1:0] != 2'h0) || periph8);
  wire ae_hit = acc_valid && (acc_fetch ? fetch_err : (word_err | long_err));
  wire ae_cpu_set = ae_hit && !acc_dma;
  wire ae_dma_set = ae_hit && acc_dma && !acc_fetch;

  // Source grouping onto priority fields
  logic [NGRP-1:0] grp_req;
  assign grp_req[7:0] = ext_s_q;
  assign grp_req[8] = |dma_req;
  assign grp_req[18] = wdt_req;
  assign grp_req[19] = |bsc_req;
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_tmr
      assign grp_req[9 + g] = |timer_req[g*3 +: 3];
    end
    for (g = 0; g < 4; g++) begin : g_ser
      assign grp_req[14 + g] = |serial_req[g*2 +: 2];
    end
  endgenerate

  // Priority chain; lower index wins a tie
  logic [4:0] lvl_c [0:NGRP];
  logic [7:0] vec_c [0:NGRP];
  assign lvl_c[0] = ubrk_req ? `UBRK_LEVEL : 5'h00;
  assign vec_c[0] = `VEC_UBRK;
  generate
    for (g = 0; g < NGRP; g++) begin : g_arb
      wire [4:0] fld = {1'b0, prio_q[g/4][(g%4)*4 +: 4]};
      wire win = grp_req[g] && (fld > lvl_c[g]);
      assign lvl_c[g+1] = win ? fld : lvl_c[g];
      assign vec_c[g+1] = win ? (`VEC_GRP_BASE + 8'(g)) : vec_c[g];
    end
  endgenerate

  wire [4:0] best_lvl = lvl_c[NGRP];
  wire int_ok = best_lvl > {1'b0, cur_sr[`SR_MASK_LSB +: 4]};
  wire run = (state_q == exc_pkg::ST_RUN) && init_s_q;
  wire ae_pend = ae_cpu_q | ae_dma_q;
  wire take_ae = run && ae_pend && ae_window && !bus_busy;
  wire take_int = run && !take_ae && int_window && (nmi_pend_q || int_ok);
  wire take_nmi = take_int && nmi_pend_q;
  wire [7:0] int_vec = nmi_pend_q ? `VEC_NMI : vec_c[NGRP];
  wire [3:0] int_mask = nmi_pend_q ? `NMI_MASK : best_lvl[3:0];
  wire nmi_rise = nmi_s_q && !nmi_d1_q && init_s_q;
  wire start_rst = (state_q == exc_pkg::ST_HOLD) && init_s_q;

  // Vector and stack addresses
  wire [31:0] vec_addr = vbr_q + {22'h0, vec_q, 2'b00};
  wire [31:0] sp_m4 = sp_q - 32'h4;
  wire [31:0] sp_m8 = sp_q - 32'h8;

  // Sequencer
  always_comb begin
    state_d = state_q;
    if (!init_s_q && state_q != exc_pkg::ST_HOLD && state_q != exc_pkg::ST_DRAIN) begin
      state_d = (!nmi_s_q && bus_busy) ? exc_pkg::ST_DRAIN : exc_pkg::ST_HOLD;
    end else begin
      unique case (state_q)
        exc_pkg::ST_RUN: if (take_ae || take_int) state_d = exc_pkg::ST_PUSH_SR;
        exc_pkg::ST_DRAIN: if (!bus_busy) state_d = exc_pkg::ST_HOLD;
        exc_pkg::ST_HOLD: if (init_s_q) state_d = exc_pkg::ST_VEC_PC;
        exc_pkg::ST_VEC_PC: if (mem_ack) state_d = exc_pkg::ST_VEC_SP;
        exc_pkg::ST_VEC_SP: if (mem_ack) state_d = exc_pkg::ST_LOAD;
        exc_pkg::ST_PUSH_SR: if (mem_ack) state_d = exc_pkg::ST_PUSH_PC;
        exc_pkg::ST_PUSH_PC: if (mem_ack) state_d = exc_pkg::ST_VEC_FETCH;
        exc_pkg::ST_VEC_FETCH: if (mem_ack) state_d = exc_pkg::ST_LOAD;
        exc_pkg::ST_LOAD: state_d = exc_pkg::ST_RUN;
        default: state_d = exc_pkg::ST_HOLD;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= exc_pkg::ST_HOLD;
      kind_q <= 1'b1;
      core_rst_q <= 1'b0;
      sys_rst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_d == exc_pkg::ST_HOLD || state_d == exc_pkg::ST_DRAIN) begin
        kind_q <= nmi_s_q;
      end
      core_rst_q <= state_d != exc_pkg::ST_HOLD;
      sys_rst_q <= !(state_d == exc_pkg::ST_HOLD && nmi_s_q);
    end
  end

  // Pending flags; a set wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == exc_pkg::ST_HOLD) begin
      nmi_pend_q <= 1'b0;
      ae_cpu_q <= 1'b0;
      ae_dma_q <= 1'b0;
      fault_q <= 32'h0000_0000;
      ae_pulse_q <= 1'b0;
    end else begin
      nmi_pend_q <= nmi_rise | (nmi_pend_q & ~take_nmi);
      ae_cpu_q <= ae_cpu_set | (ae_cpu_q & ~take_ae);
      ae_dma_q <= ae_dma_set | (ae_dma_q & ~(take_ae & ~ae_cpu_q));
      ae_pulse_q <= ae_hit;
      if (ae_hit) begin
        fault_q <= acc_addr;
      end
    end
  end

  // Sequence context
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_q <= `VEC_POR_PC;
      mask_q <= `MASK_RESET;
      rst_seq_q <= 1'b1;
      sr_q <= 32'h0000_0000;
      ret_q <= 32'h0000_0000;
      sp_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
      vbr_q <= 32'h0000_0000;
    end else if (start_rst) begin
      vec_q <= kind_q ? `VEC_POR_PC : `VEC_MAN_PC;
      vbr_q <= 32'h0000_0000;
      mask_q <= `MASK_RESET;
      sr_q <= 32'h0000_0000;
      rst_seq_q <= 1'b1;
    end else if (take_ae || take_int) begin
      vec_q <= take_ae ? (ae_cpu_q ? `VEC_CPU_AE : `VEC_DMA_AE) : int_vec;
      mask_q <= take_ae ? cur_sr[`SR_MASK_LSB +: 4] : int_mask;
      sr_q <= cur_sr;
      ret_q <= cur_pc;
      sp_q <= cur_sp;
      vbr_q <= vector_table_base;
      rst_seq_q <= 1'b0;
    end else if (mem_ack) begin
      if (state_q == exc_pkg::ST_VEC_PC || state_q == exc_pkg::ST_VEC_FETCH) pc_q <= mem_rdata;
      if (state_q == exc_pkg::ST_VEC_SP) sp_q <= mem_rdata;
      if (state_q == exc_pkg::ST_PUSH_PC) sp_q <= sp_m8;
    end
  end

  // Memory port
  wire st_vpc = state_q == exc_pkg::ST_VEC_PC;
  wire st_vsp = state_q == exc_pkg::ST_VEC_SP;
  wire st_psr = state_q == exc_pkg::ST_PUSH_SR;
  wire st_ppc = state_q == exc_pkg::ST_PUSH_PC;
  wire st_vft = state_q == exc_pkg::ST_VEC_FETCH;
  assign mem_req = st_vpc | st_vsp | st_psr | st_ppc | st_vft;
  assign mem_we = st_psr | st_ppc;
  assign mem_addr = st_psr ? sp_m4 : st_ppc ? sp_m8 : st_vsp ? vec_addr + 32'h4 : vec_addr;
  assign mem_wdata = st_psr ? sr_q : ret_q;

  // Pipeline outputs
  assign cpu_stall = state_q != exc_pkg::ST_RUN;
  assign load_valid = state_q == exc_pkg::ST_LOAD;
  assign load_pc = pc_q;
  assign load_sp = sp_q;
  assign load_sr = {sr_q[31:`SR_MASK_LSB+4], mask_q, sr_q[`SR_MASK_LSB-1:0]};
  assign vbr_clear = load_valid && rst_seq_q;
  assign addr_error = ae_pulse_q;
  assign core_rst_n = core_rst_q;
  assign sys_rst_n = sys_rst_q;

  // AXI4-Lite write channel
  logic aw_q, w_q, bvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  wire do_wr = aw_q && w_q && !bvalid_q;
  wire [2:0] wr_idx = reg_idx(awaddr_q);
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_idx == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Priority level registers, cleared by either reset kind
  generate
    for (g = 0; g < 5; g++) begin : g_prio
      wire hit = do_wr && (wr_idx == 3'(g));
      always_ff @(posedge aclk) begin
        if (!aresetn || state_q == exc_pkg::ST_HOLD) begin
          prio_q[g] <= `PRIO_RESET;
        end else if (hit) begin
          if (wstrb_q[0]) prio_q[g][7:0] <= wdata_q[7:0];
          if (wstrb_q[1]) prio_q[g][15:8] <= wdata_q[15:8];
        end
      end
    end
  endgenerate

  // AXI4-Lite read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire [2:0] rd_idx = reg_idx(s_axi_araddr);
  wire [31:0] status_w = {18'h00000, best_lvl, 1'b0, state_q, kind_q, nmi_pend_q, ae_dma_q, ae_cpu_q};
  wire [31:0] rd_word = (rd_idx < 3'h5) ? {16'h0000, prio_q[rd_idx]} :
                        (rd_idx == 3'h5) ? status_w :
                        (rd_idx == 3'h6) ? fault_q : 32'h0000_0000;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (rd_idx == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ### verif/exc_mem_model.sv
`timescale 1ns/1ps
module exc_mem_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Exception memory port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [1:0] lag_q;
  logic [1:0] wait_q;
  // Answer delay cycles through 0..3; data bus toggles when idle
  always @(posedge aclk) begin
    lag_q <= lag_q + 2'h1;
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!aresetn) begin
      lag_q <= 2'h0;
      wait_q <= 2'h0;
      mem_rdata <= 32'h0f0f_0f0f;
    end else if (mem_req && !mem_ack) begin
      if (wait_q == 2'h0) begin
        mem_ack <= 1'b1;
        mem_rdata <= {mem_addr[15:0] ^ 16'h5a5a, ~mem_addr[15:0]};
        wait_q <= lag_q;
      end else begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule

// ### verif/exc_monitor.sv
`timescale 1ns/1ps
`include "exc_defs.svh"
module exc_monitor #(
  parameter logic [31:0] PERIPH_MASK = 32'hffff_0000,
  parameter logic [31:0] PERIPH_BASE = 32'hffff_0000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Access check
  input wire logic acc_valid,
  input wire logic acc_fetch,
  input wire logic [1:0] acc_size,
  input wire logic [31:0] acc_addr,
  input wire logic addr_error,
  // Pipeline
  input wire logic [31:0] cur_sr,
  input wire logic [31:0] cur_pc,
  input wire logic cpu_stall,
  input wire logic load_valid,
  input wire logic [31:0] load_sr,
  input wire logic vbr_clear,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire data_acc = acc_valid && !acc_fetch;
  wire rd_done = mem_req && !mem_we && mem_ack;
  wire rst_vec = mem_addr == 32'h0000_0000 || mem_addr == 32'h0000_0008;
  sequence sr_pushed;
    mem_req && mem_we && mem_ack && mem_wdata == cur_sr;
  endsequence
  sequence pc_offered;
    mem_req && mem_we && mem_wdata == cur_pc && mem_addr == $past(mem_addr) - 32'd4;
  endsequence
  sequence pc_pushed;
    mem_req && mem_we && mem_ack && mem_wdata == cur_pc;
  endsequence
  AST_ODD_FETCH: assert property (acc_valid && acc_fetch && acc_addr[0] |=> addr_error)
    else $error("odd fetch not flagged");
  AST_PERIPH_FETCH: assert property (acc_valid && acc_fetch && (acc_addr & PERIPH_MASK) == PERIPH_BASE |=> addr_error)
    else $error("peripheral fetch not flagged");
  AST_WORD_ODD: assert property (data_acc && acc_size == `SZ_WORD && acc_addr[0] |=> addr_error)
    else $error("odd word access not flagged");
  AST_LONG_MISALIGN: assert property (data_acc && acc_size == `SZ_LONG && acc_addr[1:0] != 2'h0 |=> addr_error)
    else $error("misaligned long access not flagged");
  AST_BYTE_OK: assert property (data_acc && acc_size == `SZ_BYTE |=> !addr_error)
    else $error("byte access flagged");
  AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  AST_STACK_ORDER: assert property (sr_pushed |=> pc_offered)
    else $error("return address not pushed after status word");
  AST_VEC_AFTER_STACK: assert property (pc_pushed |=> mem_req && !mem_we)
    else $error("vector fetch does not follow stacking");
  AST_RESET_VEC_PAIR: assert property (rd_done && rst_vec |=> mem_req && !mem_we && mem_addr == $past(mem_addr) + 32'd4)
    else $error("stack vector not read after start vector");
  AST_LOAD_AFTER_VEC: assert property (rd_done && !rst_vec |=> load_valid)
    else $error("load missing after vector read");
  AST_VBR_WITH_LOAD: assert property (vbr_clear |-> load_valid && load_sr[7:4] == 4'hf)
    else $error("base clear without full mask load");
  AST_LOAD_CLEARS_STALL: assert property (load_valid |-> cpu_stall ##1 !cpu_stall)
    else $error("execution not resumed after load");
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
`include "exc_defs.svh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic nmi_pin = 1'b1;
  logic chip_init_pin = 1'b1;
  logic [7:0] external_request_lines = 8'h00;
  logic ubrk_req = 1'b0;
  logic wdt_req = 1'b0;
  logic [3:0] dma_req = 4'h0;
  logic [14:0] timer_req = 15'h0000;
  logic [7:0] serial_req = 8'h00;
  logic [1:0] bsc_req = 2'h0;
  logic acc_valid = 1'b0;
  logic acc_dma = 1'b0;
  logic acc_fetch = 1'b0;
  logic [1:0] acc_size = 2'h0;
  logic [31:0] acc_addr = 32'h0000_0000;
  logic bus_busy = 1'b0;
  logic int_window = 1'b1;
  logic ae_window = 1'b0;
  logic [31:0] cur_sr = 32'h0000_03f3;
  logic [31:0] cur_pc = 32'h0000_1000;
  logic [31:0] cur_sp = 32'h0000_2000;
  logic [31:0] vector_table_base = 32'h0001_0000;
  logic cpu_stall, load_valid, vbr_clear, addr_error, core_rst_n, sys_rst_n, mem_req, mem_we, mem_ack;
  logic [31:0] load_pc, load_sp, load_sr, mem_addr, mem_wdata, mem_rdata;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_errors = 0;
  int n_checks = 0;
  logic [64:0] exp_q[$];
  logic [68:0] ld_q[$];
  logic [64:0] e;
  logic [68:0] l;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [31:0] t_addr [12] = '{32'h1000, 32'h1001, 32'hffff_0010, 32'h2002, 32'h2003, 32'h2004,
                               32'h2006, 32'hffff_0011, 32'hffff_0012, 32'hffff_0014, 32'hffff_ff04, 32'h2001};
  logic [3:0] t_kind [12] = '{4'h5, 4'h5, 4'h5, 4'h1, 4'h9, 4'h2, 4'ha, 4'h0, 4'h9, 4'h2, 4'h2, 4'h8};
  logic [11:0] t_err = 12'h456;

  exc_seq uut (.*);
  exc_mem_model mem (.*);

  always #5 aclk = ~aclk;

  task automatic check(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] vec_data(input logic [31:0] a);
    return {a[15:0] ^ 16'h5a5a, ~a[15:0]};
  endfunction

  task automatic exp_reset(input logic [31:0] base);
    exp_q.push_back({1'b0, base, 32'h0});
    exp_q.push_back({1'b0, base + 32'd4, 32'h0});
    ld_q.push_back({1'b1, vec_data(base), vec_data(base + 32'd4), 4'hf});
  endtask

  task automatic exp_exc(input logic [7:0] vec, input logic [3:0] mask);
    logic [31:0] a;
    a = vector_table_base + {22'h0, vec, 2'b00};
    exp_q.push_back({1'b1, cur_sp - 32'd4, cur_sr});
    exp_q.push_back({1'b1, cur_sp - 32'd8, cur_pc});
    exp_q.push_back({1'b0, a, 32'h0});
    ld_q.push_back({1'b0, vec_data(a), cur_sp - 32'd8, mask});
  endtask

  task automatic take(input logic [3:0] m, input logic [7:0] vec, input logic [3:0] newm);
    @(posedge aclk);
    cur_sr[7:4] <= m;
    @(posedge aclk);
    exp_exc(vec, newm);
  endtask

  task automatic settle();
    while (exp_q.size() > 0 || ld_q.size() > 0) @(posedge aclk);
    repeat (3) @(posedge aclk);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge aclk);
      check(mem_req === 1'b0 && load_valid === 1'b0, "exception started too early");
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  // Scoreboard of memory operations and loads; loaded mask fed back like the core would
  always @(posedge aclk) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      check(mem_we === e[64] && mem_addr === e[63:32] && (!e[64] || mem_wdata === e[31:0]), "memory op");
    end
    if (load_valid === 1'b1) begin
      l = ld_q.size() > 0 ? ld_q.pop_front() : '1;
      check(vbr_clear === l[68] && load_pc === l[67:36] && load_sp === l[35:4] && load_sr[7:4] === l[3:0],
            "register load");
      cur_sr[7:4] <= l[3:0];
    end
  end

  initial begin
    rd = $urandom(32'haeda);
    exp_reset(32'h0);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cur_pc <= $urandom & 32'hffff_fffe;
    cur_sp <= {4'h2, 28'($urandom) & 28'hfff_fff0};
    vector_table_base <= {4'h3, 12'($urandom), 16'h0000};
    repeat (2) @(posedge aclk);
    check(sys_rst_n === 1'b0 && core_rst_n === 1'b0, "power-on reset not applied");
    settle();
    nmi_pin <= 1'b0;
    bus_busy <= 1'b1;
    chip_init_pin <= 1'b0;
    exp_reset(32'h8);
    repeat (20) begin
      @(posedge aclk);
      check(sys_rst_n === 1'b1, "manual reset hit system units");
    end
    chip_init_pin <= 1'b1;
    quiet(8);
    bus_busy <= 1'b0;
    settle();
    for (int i = 0; i < 12; i++) begin
      @(posedge aclk);
      acc_valid <= 1'b1;
      {acc_dma, acc_fetch, acc_size} <= t_kind[i];
      acc_addr <= t_addr[i][31:16] == 16'hffff ? t_addr[i] : t_addr[i] | ($urandom & 32'h0fff_fff0);
      @(posedge aclk);
      acc_valid <= 1'b0;
      @(posedge aclk);
      check(addr_error === t_err[i], "address check");
    end
    exp_exc(`VEC_CPU_AE, 4'hf);
    exp_exc(`VEC_DMA_AE, 4'hf);
    ae_window <= 1'b1;
    bus_busy <= 1'b1;
    quiet(8);
    bus_busy <= 1'b0;
    settle();
    ae_window <= 1'b0;
    axi_wr(`OFF_PRIO_A, 32'h0000_0035);
    check(rs === `RESP_OKAY, "write response");
    axi_rd(`OFF_PRIO_A);
    check(rd[15:0] === 16'h0035 && rs === `RESP_OKAY, "priority readback");
    axi_rd(8'h40);
    check(rs === `RESP_SLVERR, "unmapped read");
    axi_wr(8'h40, 32'h0000_00ff);
    check(rs === `RESP_SLVERR, "unmapped write");
    axi_rd(`OFF_FAULT);
    check(rd === 32'hffff_ff04 && rs === `RESP_OKAY, "fault address");
    take(4'h4, `VEC_GRP_BASE, 4'h5);
    external_request_lines <= 8'h03;
    settle();
    quiet(10);
    external_request_lines <= 8'h00;
    axi_wr(`OFF_PRIO_C, 32'h0000_0007);
    take(4'h0, `VEC_GRP_BASE + 8'h08, 4'h7);
    dma_req <= 4'h1 | 4'($urandom);
    timer_req <= 15'($urandom);
    serial_req <= 8'($urandom);
    wdt_req <= 1'b1;
    bsc_req <= 2'h3;
    settle();
    quiet(10);
    take(4'he, `VEC_UBRK, 4'hf);
    ubrk_req <= 1'b1;
    settle();
    {ubrk_req, dma_req, timer_req, serial_req, wdt_req, bsc_req} <= '0;
    take(4'hf, `VEC_NMI, `NMI_MASK);
    nmi_pin <= 1'b1;
    settle();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule

bind exc_seq exc_monitor #(.PERIPH_MASK(PERIPH_MASK), .PERIPH_BASE(PERIPH_BASE)) mon (.*);
